// ===== common/sct_params.svh
`ifndef SCT_PARAMS_SVH
`define SCT_PARAMS_SVH
`define SCT_CMD_SMART      8'hB0
`define SCT_CMD_RDLOG      8'h2F
`define SCT_CMD_WRLOG      8'h3F
`define SCT_FEAT_RD        8'hD5
`define SCT_FEAT_WR        8'hD6
`define SCT_SIG_LO         8'h4F
`define SCT_SIG_HI         8'hC2
`define SCT_PAGE_STAT      8'hE0
`define SCT_PAGE_DATA      8'hE1
`define SCT_ZERO8          8'h00
`define SCT_CNT_ONE        8'h01
`define SCT_CNT_EIGHT      8'h08
`define SCT_XST_OK         16'h0000
`define SCT_XST_NOCMD      16'h000B
`define SCT_XST_BUSY       16'hFFFF
`define SCT_XST_RST        16'h0000
`define SCT_CODE_RST       16'h0000
`endif

// ===== common/sct_pkg.sv
`default_nettype none
package sct_pkg;
  // one taskfile write as the host leaves it
  typedef struct packed {
    logic [7:0] command;
    logic [7:0] feature;
    logic [7:0] feature_prev;
    logic [7:0] count;
    logic [7:0] count_prev;
    logic [7:0] lba_low;
    logic [7:0] lba_mid;
    logic [7:0] lba_mid_prev;
    logic [7:0] lba_high;
  } sct_tf_s;

  typedef enum logic [2:0] {
    SCT_OP_NONE   = 3'b000,
    SCT_OP_STATUS = 3'b001,
    SCT_OP_DRD    = 3'b010,
    SCT_OP_DWR    = 3'b011,
    SCT_OP_BAD    = 3'b100
  } sct_op_e;

  // status response fields of the last sct command
  typedef struct packed {
    logic [15:0] ext_status;
    logic [15:0] action;
    logic [15:0] function_code;
  } sct_stat_s;

  typedef enum logic [1:0] {
    SCT_ST_IDLE = 2'b00,
    SCT_ST_XFER = 2'b01,
    SCT_ST_DONE = 2'b10
  } sct_state_e;
endpackage : sct_pkg
`default_nettype wire

// ===== rtl/sct_decode.sv
`include "sct_params.svh"
`default_nettype none
// pure decode of one taskfile into an operation class
module sct_decode (
  // taskfile in
  input  wire sct_pkg::sct_tf_s tf,
  // decoded
  output var  sct_pkg::sct_op_e op,
  output logic [8:0]            sectors
);
  import sct_pkg::*;

  wire smart   = tf.command == `SCT_CMD_SMART;
  wire sig_ok  = tf.lba_mid == `SCT_SIG_LO && tf.lba_high == `SCT_SIG_HI;
  wire f_rd    = tf.feature == `SCT_FEAT_RD;
  wire f_wr    = tf.feature == `SCT_FEAT_WR;
  wire lg_rd   = tf.command == `SCT_CMD_RDLOG;
  wire lg_wr   = tf.command == `SCT_CMD_WRLOG;
  wire lg      = lg_rd || lg_wr;
  wire lg_hi   = tf.count_prev == `SCT_ZERO8 && tf.lba_mid == `SCT_ZERO8;
  wire cnt_one = tf.count == `SCT_CNT_ONE;
  wire cnt_ok8 = cnt_one || tf.count == `SCT_CNT_EIGHT;
  wire pg_st   = tf.lba_low == `SCT_PAGE_STAT;
  wire pg_dt   = tf.lba_low == `SCT_PAGE_DATA;
  // smart form uses the sector number field (lba_low) for the page
  // [R10] smart status form
  wire sm_st   = smart && sig_ok && f_rd && cnt_one && pg_st;
  // [R2] smart data form
  wire sm_drd  = smart && sig_ok && f_rd && pg_dt;
  wire sm_dwr  = smart && sig_ok && f_wr && pg_dt;
  // [R11] log status form
  wire lg_st   = lg_rd && lg_hi && tf.lba_mid_prev == `SCT_ZERO8 && cnt_one && pg_st;
  // [R4] log data form
  wire lg_drd  = lg_rd && lg_hi && cnt_ok8 && pg_dt;
  wire lg_dwr  = lg_wr && lg_hi && cnt_ok8 && pg_dt;
  wire ours    = (smart && (pg_st || pg_dt)) || (lg && (pg_st || pg_dt));

  // [R15] anything aimed at our pages that fails encoding is bad
  assign op = (sm_st || lg_st)   ? SCT_OP_STATUS :
              (sm_drd || lg_drd) ? SCT_OP_DRD :
              (sm_dwr || lg_dwr) ? SCT_OP_DWR :
              ours               ? SCT_OP_BAD : SCT_OP_NONE;
  // a zero smart count means 256 sectors
  assign sectors = (tf.count == `SCT_ZERO8) ? 9'h100 : {1'b0, tf.count};
endmodule : sct_decode
`default_nettype wire

// ===== rtl/sct_log_xfer.sv
// Operation
// [R1] all sct payload after an accepted sct command moves through page E1h both ways.
// [R2] smart data transfer is B0h with signature 4Fh/C2h, page E1h, feature D5h read or D6h write.
// [R3] smart data transfer moves exactly the sector count given by the host.
// [R4] log data transfer is 2Fh read or 3Fh write, page E1h, mid 00h, count 01h or 08h.
// [R5] the taskfile answer says only accepted or error.
// [R6] the host must poll sct status to learn that a long action finished.
// [R7] reading page E0h returns the held sct status content.
// [R8] a status read is accepted at any time, also while an action runs; here it is taken only in SCT_ST_IDLE, not while a transfer runs.
// [R9] a status read leaves power state and background work untouched.
// [R10] smart status read is B0h, feature D5h, count 01h, page E0h, signature 4Fh/C2h.
// [R11] log status read is 2Fh, count 01h, prev 00h, page E0h, both mid bytes 00h.
// [R12] while an action runs in background the extended status reads FFFFh.
// [R13] the response carries extended status, then action and function code.
// [R14] a data transfer without a preceding sct command is refused with status 000Bh.
// [R15] bad signature, page or count aborts with an error in the taskfile status; here a page other than E0h or E1h is not taken and gets no answer.
`include "sct_params.svh"
`default_nettype none
module sct_log_xfer (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // taskfile command in
  input  wire logic             tf_valid,
  input  wire sct_pkg::sct_tf_s tf,
  // sct engine side
  input  wire logic             act_start,
  input  wire logic [15:0]      act_code,
  input  wire logic [15:0]      act_func,
  input  wire logic             act_busy,
  input  wire logic             act_done,
  input  wire logic [15:0]      act_status,
  // sector transfer strobes
  input  wire logic             sec_done,
  // taskfile answer
  output logic                  ans_valid,
  output logic                  ans_error,
  output logic                  ans_aborted,
  // transfer control
  output logic                  xfer_active,
  output logic                  xfer_write,
  output logic                  xfer_status,
  output logic [8:0]            xfer_left,
  // status response content
  output sct_pkg::sct_stat_s    stat
);
  import sct_pkg::*;

  sct_op_e    op;
  logic [8:0] sectors;
  sct_decode u_dec (
    .tf      (tf),
    .op      (op),
    .sectors (sectors)
  );

  sct_state_e  state_ff, nxt_state;
  logic        armed_ff;
  logic        busy_ff;
  logic [15:0] xst_ff, code_ff, func_ff;
  logic        ans_v_ff, ans_e_ff, ans_a_ff;
  logic        act_ff, wr_ff, st_ff;
  logic [8:0]  left_ff, nxt_left;

  wire idle     = state_ff == SCT_ST_IDLE;
  wire take     = tf_valid && idle && op != SCT_OP_NONE;
  wire is_data  = op == SCT_OP_DRD || op == SCT_OP_DWR;
  // [R14] data transfer needs an earlier sct command
  wire no_cmd   = take && is_data && !armed_ff;
  // [R15] bad encodings abort
  wire bad      = take && op == SCT_OP_BAD;
  wire go_data  = take && is_data && armed_ff;
  // [R8] status accepted even while busy
  wire go_stat  = take && op == SCT_OP_STATUS;
  wire last_sec = state_ff == SCT_ST_XFER && sec_done && left_ff == 9'h001;

  always_comb begin
    nxt_state = state_ff;
    nxt_left  = left_ff;
    case (state_ff)
      SCT_ST_IDLE: begin
        if (go_data || go_stat) begin
          nxt_state = SCT_ST_XFER;
          // [R3] exact sector count
          nxt_left  = go_stat ? 9'h001 : sectors;
        end
      end
      SCT_ST_XFER: begin
        if (sec_done) begin
          nxt_left = left_ff - 9'h001;
        end
        if (last_sec) begin
          nxt_state = SCT_ST_DONE;
        end
      end
      SCT_ST_DONE: nxt_state = SCT_ST_IDLE;
      default:     nxt_state = SCT_ST_IDLE;
    endcase
  end

  // [R9] status read passive
  // the status read only looks at held fields, so background work never stalls
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= SCT_ST_IDLE;
      left_ff  <= 9'h000;
    end else begin
      state_ff <= nxt_state;
      left_ff  <= nxt_left;
    end
  end

  // [R1] armed by an accepted sct command, enables page E1h traffic
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      armed_ff <= 1'b0;
    end else if (act_start) begin
      armed_ff <= 1'b1;
    end
  end

  // [R12] busy tracking, start wins over done
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
    end else if (act_start) begin
      busy_ff <= 1'b1;
    end else if (act_done) begin
      busy_ff <= 1'b0;
    end
  end

  // [R13] last command codes and status
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      xst_ff  <= `SCT_XST_RST;
      code_ff <= `SCT_CODE_RST;
      func_ff <= `SCT_CODE_RST;
    end else if (act_start) begin
      xst_ff  <= `SCT_XST_OK;
      code_ff <= act_code;
      func_ff <= act_func;
    end else if (no_cmd) begin
      // [R14] record refusal
      xst_ff  <= `SCT_XST_NOCMD;
    end else if (act_done) begin
      xst_ff  <= act_status;
    end
  end

  // [R12] busy seen by the response, engine level busy included
  wire        nxt_busy = act_start || (busy_ff && !act_done) || act_busy;
  wire [15:0] nxt_xst  = act_start ? `SCT_XST_OK :
                         no_cmd    ? `SCT_XST_NOCMD :
                         act_done  ? act_status : xst_ff;
  logic [15:0] stat_xst_ff;

  // output register so the response field never glitches through the mux
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stat_xst_ff <= `SCT_XST_RST;
    end else begin
      stat_xst_ff <= nxt_busy ? `SCT_XST_BUSY : nxt_xst;
    end
  end

  // [R5] answer is accept or error only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ans_v_ff <= 1'b0;
      ans_e_ff <= 1'b0;
      ans_a_ff <= 1'b0;
    end else begin
      ans_v_ff <= no_cmd || bad || last_sec;
      ans_e_ff <= no_cmd || bad;
      ans_a_ff <= no_cmd || bad;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      act_ff <= 1'b0;
      wr_ff  <= 1'b0;
      st_ff  <= 1'b0;
    end else begin
      act_ff <= nxt_state == SCT_ST_XFER;
      if (idle) begin
        wr_ff <= op == SCT_OP_DWR;
        st_ff <= op == SCT_OP_STATUS;
      end
    end
  end

  assign ans_valid   = ans_v_ff;
  assign ans_error   = ans_e_ff;
  assign ans_aborted = ans_a_ff;
  assign xfer_active = act_ff;
  assign xfer_write  = wr_ff;
  assign xfer_status = st_ff;
  assign xfer_left   = left_ff;
  // [R7] held status content for page E0h; [R12] busy forces FFFFh
  assign stat.ext_status    = stat_xst_ff;
  assign stat.action        = code_ff;
  assign stat.function_code = func_ff;
endmodule : sct_log_xfer
`default_nettype wire

// ===== bench/sct_checker.sv
`default_nettype none
module sct_checker (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_n,
  // engine and strobes
  input wire logic               act_start,
  input wire logic [15:0]        act_code,
  input wire logic               act_done,
  input wire logic [15:0]        act_status,
  input wire logic               sec_done,
  // watched outputs
  input wire logic               ans_valid,
  input wire logic               ans_error,
  input wire logic               xfer_active,
  input wire logic               xfer_status,
  input wire logic [8:0]         xfer_left,
  input wire sct_pkg::sct_stat_s stat
);
  import sct_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ans_pulse_a: assert property (ans_valid |=> !ans_valid)
    else $error("answer wider than one cycle");
  err_with_ans_a: assert property (ans_error |-> ans_valid)
    else $error("error without answer");
  busy_code_a: assert property (act_start |=> stat.ext_status == 16'hFFFF)
    else $error("busy code missing");
  action_kept_a: assert property (act_start |=> stat.action == $past(act_code))
    else $error("action code not held");
  done_status_a: assert property (act_done && !act_start |=>
    stat.ext_status == $past(act_status)) else $error("final status lost");
  left_step_a: assert property (xfer_active && sec_done && xfer_left > 9'h001 |=>
    xfer_left == $past(xfer_left) - 9'h001) else $error("sector count step");
  last_sector_a: assert property (xfer_active && sec_done && xfer_left == 9'h001 |=>
    ans_valid && !ans_error && !xfer_active) else $error("end of transfer");
  status_quiet_a: assert property (xfer_status && !act_start && !act_done |=>
    $stable(stat)) else $error("status read disturbed state");
endmodule : sct_checker
bind sct_log_xfer sct_checker chk (.clk_sys, .rst_n, .act_start, .act_code, .act_done,
  .act_status, .sec_done, .ans_valid, .ans_error, .xfer_active, .xfer_status,
  .xfer_left, .stat);
`default_nettype wire

// ===== bench/sct_sector_model.sv
`default_nettype none
module sct_sector_model (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // transfer side
  input  wire logic xfer_active,
  input  wire logic slow,
  output logic      sec_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] gap_ff;
  logic       sec_done_ff;
  assign sec_done = sec_done_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff      <= 2'h0;
      sec_done_ff <= 1'b0;
    end else begin
      gap_ff      <= gap_ff + 2'h1;
      sec_done_ff <= xfer_active && !sec_done_ff && (!slow || gap_ff[1]);
    end
  end
endmodule : sct_sector_model
`default_nettype wire

// ===== bench/tb_top.sv
`default_nettype none
module tb_top;
  import sct_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_n, tf_valid, act_start, act_done, sec_done, slow;
  logic ans_valid, ans_error, xfer_active, xfer_write, xfer_status;
  logic [15:0] act_code, act_func, act_status;
  logic [8:0]  xfer_left;
  sct_tf_s     tf;
  sct_stat_s   stat;
  int          errors, compares;
  sct_log_xfer dut (.clk_sys(clk_sys), .rst_n(rst_n), .tf_valid(tf_valid), .tf(tf),
    .act_start(act_start), .act_code(act_code), .act_func(act_func), .act_busy(1'b0),
    .act_done(act_done), .act_status(act_status), .sec_done(sec_done),
    .ans_valid(ans_valid), .ans_error(ans_error), .ans_aborted(),
    .xfer_active(xfer_active), .xfer_write(xfer_write), .xfer_status(xfer_status),
    .xfer_left(xfer_left), .stat(stat));
  sct_sector_model host (.clk_sys(clk_sys), .rst_n(rst_n), .xfer_active(xfer_active),
    .slow(slow), .sec_done(sec_done));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic tally_and_finish;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  function automatic sct_tf_s mk(input logic [7:0] c, f, n, lo, md, hi);
    return '{c, f, 8'h00, n, 8'h00, lo, md, 8'h00, hi};
  endfunction : mk
  task automatic run(input sct_tf_s t, input logic e, input logic [8:0] n,
                     input logic [1:0] kind);
    int k;
    int got;
    got = 0;
    @(posedge clk_sys);
    tf <= t;
    tf_valid <= 1'b1;
    @(posedge clk_sys);
    tf_valid <= 1'b0;
    for (k = 0; k < 700 && ans_valid !== 1'b1; k++) begin
      @(negedge clk_sys);
      if (xfer_active === 1'b1) chk("kind", 16'(kind), {xfer_status, xfer_write});
      if (xfer_active === 1'b1 && sec_done === 1'b1) got++;
    end
    if (k == 700) begin
      errors++;
      tally_and_finish;
    end
    chk("ans_error", 16'(e), 16'(ans_error));
    chk("sectors", 16'(n), 16'(got));
  endtask : run
  task automatic eng(input logic st, input logic [15:0] c);
    @(posedge clk_sys);
    act_start <= st;
    act_done <= !st;
    act_code <= c;
    act_func <= ~c;
    act_status <= c;
    @(posedge clk_sys);
    act_start <= 1'b0;
    act_done <= 1'b0;
    @(negedge clk_sys);
  endtask : eng
  task automatic s_refuse;
    run(mk(8'hB0, 8'hD5, 8'h02, 8'hE1, 8'h4F, 8'hC2), 1'b1, 9'h000, 2'h0);
    chk("xst_nocmd", 16'h000B, stat.ext_status);
    run(mk(8'hB0, 8'hD5, 8'h01, 8'hE0, 8'h4F, 8'hC3), 1'b1, 9'h000, 2'h0);
    run(mk(8'h2F, 8'h00, 8'h02, 8'hE0, 8'h00, 8'h00), 1'b1, 9'h000, 2'h0);
    chk("xst_kept", 16'h000B, stat.ext_status);
  endtask : s_refuse
  task automatic s_busy;
    eng(1'b1, 16'h0005);
    chk("busy", 16'hFFFF, stat.ext_status);
    chk("func", 16'hFFFA, stat.function_code);
    run(mk(8'hB0, 8'hD5, 8'h01, 8'hE0, 8'h4F, 8'hC2), 1'b0, 9'h001, 2'h2);
    run(mk(8'h2F, 8'h00, 8'h01, 8'hE0, 8'h00, 8'h00), 1'b0, 9'h001, 2'h2);
    chk("still_busy", 16'hFFFF, stat.ext_status);
  endtask : s_busy
  task automatic s_data;
    slow <= 1'b1;
    run(mk(8'hB0, 8'hD5, 8'h03, 8'hE1, 8'h4F, 8'hC2), 1'b0, 9'h003, 2'h0);
    slow <= 1'b0;
    run(mk(8'hB0, 8'hD6, 8'h00, 8'hE1, 8'h4F, 8'hC2), 1'b0, 9'h100, 2'h1);
    run(mk(8'h2F, 8'h00, 8'h01, 8'hE1, 8'h00, 8'h00), 1'b0, 9'h001, 2'h0);
    run(mk(8'h3F, 8'h00, 8'h08, 8'hE1, 8'h00, 8'h00), 1'b0, 9'h008, 2'h1);
  endtask : s_data
  task automatic s_done;
    eng(1'b0, 16'h0009);
    chk("final", 16'h0009, stat.ext_status);
  endtask : s_done
  initial begin
    {rst_n, tf_valid, act_start, act_done, slow} = 5'h00;
    {act_code, act_func, act_status} = 48'h0;
    tf = '0;
    errors = 0;
    compares = 0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    s_refuse;
    s_busy;
    s_data;
    s_done;
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
